// >>> mon_entry_pkg.sv
// package: constants for monitor mode entry and link control
// assumes: 50 MHz core clock, 16-bit bus addresses, vectors read as two 8-bit bytes
package mon_entry_pkg;
  // ------------------------------------------------------------
  // vectors
  // ------------------------------------------------------------
  localparam logic [15:0] USER_RESET_VEC = 16'hFFFE;
  localparam logic [15:0] USER_SWI_VEC = 16'hFFFC;
  localparam logic [15:0] MON_RESET_VEC = 16'hFEFE;
  localparam logic [15:0] MON_SWI_VEC = 16'hFEFC;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // ------------------------------------------------------------
  // link
  // ------------------------------------------------------------
  localparam int SECURITY_BYTES = 8;
  localparam int BREAK_BITS = 10;
  localparam int FRAME_BITS = 10;
  localparam int CLK_MHZ = 50;
  localparam int BAUD = 9600;
  localparam int BIT_CYCLES = (CLK_MHZ * 1000000) / BAUD;
  localparam logic [12:0] BIT_CYCLES_W = 13'(BIT_CYCLES);
  // ------------------------------------------------------------
  // clock selections
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CLK_DIV2 = 2'b00,
    CLK_DIV4 = 2'b01,
    CLK_PLL = 2'b11,
    CLK_XTAL = 2'b10
  } clk_sel_t;
  // link states, gray along the usual path
  typedef enum logic [2:0] {
    LK_IDLE = 3'b000,
    LK_SEC = 3'b001,
    LK_BRK = 3'b011,
    LK_CMD = 3'b010,
    LK_DONE = 3'b110
  } link_state_t;
endpackage

// >>> mon_bit_timer.sv
// holds: bit-period timer for the monitor link
// assumes: one clock, synchronous inputs
`timescale 1ns/1ps
module mon_bit_timer
  import mon_entry_pkg::*;
#(
  // bit period in core clocks; the default gives the monitor baud rate
  parameter logic [12:0] BIT_LEN = BIT_CYCLES_W
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic restart,
  output logic bit_tick
);
  logic [12:0] cnt_r;
  logic [12:0] cnt_nxt;

  always_comb begin
    bit_tick = (cnt_r == BIT_LEN - 13'h0001);
    if (restart || bit_tick) begin
      cnt_nxt = 13'h0000;
    end else begin
      cnt_nxt = cnt_r + 13'h0001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 13'h0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// >>> monitor_mode_entry_control.sv
// holds: monitor mode latch, clock select, watchdog gate, vector remap, link opening
// assumes: pins already synchronous, vector bytes read from flash, por_n from supply monitor
// Function
// R1: latch mode on external reset rising edge
// R2: wait for eight security bytes first
// R3: then send ten-bit zero break
// R4: monitor vectors live in the FE page
// R5: blank-vector entry keeps watchdog always off
// R6: high-voltage entry: watchdog off while voltage present
// R7: host may move voltage to reset pin
// R8: blank-vector entry adds one extra reset
// R9: blank-vector monitor exits only by power-on
// R10: blank vector, supply level: clock divide four
// R11: programmed vector needs test high voltage
// R12: serial pin high selects serial mode
// R13: high-voltage entry bypasses crystal oscillator
// R14: link uses nrz mark/space characters
// R15: same bit rate both directions
// R16: high-voltage: divider pin low two, high four
// R17: blank vector, interrupt low: enable pll
// R18: blank means both vector bytes erased
// R19: after break wait for first command
`timescale 1ns/1ps
module monitor_mode_entry_control
  import mon_entry_pkg::*;
#(
  // bit period in core clocks; the default gives the monitor baud rate
  parameter logic [12:0] BIT_LEN = BIT_CYCLES_W
)
(
  // clock and resets
  input wire logic clk,
  input wire logic rstn,
  input wire logic por_n,
  input wire logic ext_reset_n,
  // strap pins
  input wire logic entry_strap_pin_one,
  input wire logic entry_strap_pin_two,
  input wire logic clock_divider_select_pin,
  input wire logic entry_interrupt_pin,
  input wire logic irq_test_high_voltage,
  input wire logic rst_test_high_voltage,
  // reset vector content
  input wire logic [7:0] vec_byte_hi,
  input wire logic [7:0] vec_byte_lo,
  // cpu vector fetch
  input wire logic [15:0] cpu_vec_addr,
  output logic [15:0] vec_addr,
  // serial pin
  input wire logic host_serial_pin_in,
  output logic host_serial_pin_out,
  output logic host_serial_pin_oe,
  // mode and clock status
  output logic monitor_mode,
  output logic serial_comm,
  output logic [1:0] clk_sel,
  output logic osc_bypass,
  output logic pll_enable,
  output logic watchdog_disable,
  output logic extra_reset_req,
  output logic cmd_ready,
  output logic cmd_start
);
  // ------------------------------------------------------------
  // mode latch
  // ------------------------------------------------------------
  logic rst_d_r, rst_d_nxt;
  logic mon_r, mon_nxt;
  logic blank_r, blank_nxt;
  logic hv_r, hv_nxt;
  logic ser_r, ser_nxt;
  logic [1:0] csel_r, csel_nxt;
  logic xreset_r, xreset_nxt;
  logic xdone_r, xdone_nxt;
  logic blank_now;
  logic rise;

  function automatic logic is_blank(input logic [7:0] hi, input logic [7:0] lo);
    is_blank = (hi == ERASED_BYTE) && (lo == ERASED_BYTE); // R18
  endfunction

  always_comb begin
    blank_now = is_blank(vec_byte_hi, vec_byte_lo);
    rise = ext_reset_n && !rst_d_r;
    rst_d_nxt = ext_reset_n;
    mon_nxt = mon_r;
    blank_nxt = blank_r;
    hv_nxt = hv_r;
    ser_nxt = ser_r;
    csel_nxt = csel_r;
    xreset_nxt = 1'b0;
    xdone_nxt = xdone_r;
    // blank-vector monitor survives external reset; only power-on or rstn clears it
    if (rise && !(mon_r && blank_r)) begin // R1 R9
      ser_nxt = host_serial_pin_in; // R12
      if (irq_test_high_voltage) begin // R11
        mon_nxt = entry_strap_pin_two == 1'b0;
        hv_nxt = 1'b1;
        blank_nxt = 1'b0;
        // strap two high falls back to user mode, which runs off the crystal
        if (entry_strap_pin_two == 1'b0) begin
          csel_nxt = clock_divider_select_pin ? CLK_DIV4 : CLK_DIV2; // R16 R13
        end else begin
          csel_nxt = CLK_XTAL;
        end
      end else if (blank_now) begin
        mon_nxt = 1'b1;
        hv_nxt = 1'b0;
        blank_nxt = 1'b1;
        csel_nxt = entry_interrupt_pin ? CLK_DIV4 : CLK_PLL; // R10 R17
        if (!xdone_r) begin
          xreset_nxt = 1'b1; // R8
          xdone_nxt = 1'b1;
        end
      end else begin
        mon_nxt = 1'b0;
        hv_nxt = 1'b0;
        blank_nxt = 1'b0;
        csel_nxt = CLK_XTAL;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn or negedge por_n) begin
    if (!rstn || !por_n) begin
      rst_d_r <= 1'b0;
      mon_r <= 1'b0;
      blank_r <= 1'b0;
      hv_r <= 1'b0;
      ser_r <= 1'b0;
      csel_r <= CLK_XTAL;
      xreset_r <= 1'b0;
      xdone_r <= 1'b0;
    end else begin
      rst_d_r <= rst_d_nxt;
      mon_r <= mon_nxt;
      blank_r <= blank_nxt;
      hv_r <= hv_nxt;
      ser_r <= ser_nxt;
      csel_r <= csel_nxt;
      xreset_r <= xreset_nxt;
      xdone_r <= xdone_nxt;
    end
  end

  // ------------------------------------------------------------
  // mode effects
  // ------------------------------------------------------------
  always_comb begin
    monitor_mode = mon_r;
    serial_comm = ser_r;
    clk_sel = csel_r;
    osc_bypass = mon_r && hv_r; // R13
    pll_enable = mon_r && blank_r && (csel_r == CLK_PLL); // R17
    extra_reset_req = xreset_r;
    // moving the voltage to reset pin frees the interrupt pin
    watchdog_disable = mon_r && (blank_r || // R5
      (hv_r && (irq_test_high_voltage || rst_test_high_voltage))); // R6 R7
    vec_addr = cpu_vec_addr;
    if (mon_r) begin // R4
      if (cpu_vec_addr[15:1] == USER_RESET_VEC[15:1]) begin
        vec_addr = {MON_RESET_VEC[15:1], cpu_vec_addr[0]};
      end else if (cpu_vec_addr[15:1] == USER_SWI_VEC[15:1]) begin
        vec_addr = {MON_SWI_VEC[15:1], cpu_vec_addr[0]};
      end
    end
  end

  // ------------------------------------------------------------
  // link opening
  // ------------------------------------------------------------
  link_state_t st_r, st_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [3:0] byte_r, byte_nxt;
  logic rx_d_r, rx_d_nxt;
  logic drive_r, drive_nxt;
  logic start_r, start_nxt;
  logic restart;
  logic bit_tick;

  // one shared timer: rx and tx use identical bit time
  mon_bit_timer #(.BIT_LEN(BIT_LEN)) u_timer ( // R15
    .clk(clk),
    .rstn(rstn),
    .restart(restart),
    .bit_tick(bit_tick)
  );

  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    byte_nxt = byte_r;
    rx_d_nxt = host_serial_pin_in;
    drive_nxt = 1'b0;
    start_nxt = 1'b0;
    restart = 1'b0;
    case (st_r)
      LK_IDLE: begin
        if (mon_r && ser_r && rst_d_r) begin
          st_nxt = LK_SEC;
          byte_nxt = 4'h0;
          bit_nxt = 4'h0;
        end
      end
      LK_SEC: begin // R2 R14
        // counts nrz frames by start edge; content is not checked here
        if (bit_r == 4'h0) begin
          if (rx_d_r && !host_serial_pin_in) begin
            restart = 1'b1;
            bit_nxt = 4'h1;
          end
        end else if (bit_tick) begin
          if (bit_r == 4'(FRAME_BITS)) begin
            bit_nxt = 4'h0;
            byte_nxt = byte_r + 4'h1;
            if (byte_r == 4'(SECURITY_BYTES - 1)) begin
              st_nxt = LK_BRK;
              restart = 1'b1;
              // pin drops on the restart edge, so the break spans whole bits
              drive_nxt = 1'b1; // R3
            end
          end else begin
            bit_nxt = bit_r + 4'h1;
          end
        end
      end
      LK_BRK: begin // R3
        drive_nxt = 1'b1;
        if (bit_tick) begin
          if (bit_r == 4'(BREAK_BITS - 1)) begin
            drive_nxt = 1'b0;
            bit_nxt = 4'h0;
            st_nxt = LK_CMD;
          end else begin
            bit_nxt = bit_r + 4'h1;
          end
        end
      end
      LK_CMD: begin // R19
        if (rx_d_r && !host_serial_pin_in) begin
          start_nxt = 1'b1;
          st_nxt = LK_DONE;
        end
      end
      LK_DONE: begin
        st_nxt = LK_DONE;
      end
      default: begin
        st_nxt = LK_IDLE;
      end
    endcase
    // leaving monitor mode drops the link back to idle
    if (!mon_r) begin
      st_nxt = LK_IDLE;
      drive_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= LK_IDLE;
      bit_r <= 4'h0;
      byte_r <= 4'h0;
      rx_d_r <= 1'b1;
      drive_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      byte_r <= byte_nxt;
      rx_d_r <= rx_d_nxt;
      drive_r <= drive_nxt;
      start_r <= start_nxt;
    end
  end

  // wired-or pin: only ever pull low, pullup gives the high
  always_comb begin
    host_serial_pin_out = 1'b0;
    host_serial_pin_oe = drive_r;
    cmd_ready = (st_r == LK_CMD);
    cmd_start = start_r;
  end
endmodule

// >>> mon_entry_properties.sv
// checker: port relations of the monitor entry block
// assumes: bound to the top module, one clock
`timescale 1ns/1ps
module mon_entry_properties
  import mon_entry_pkg::*;
#(
  parameter logic [12:0] BIT_LEN = BIT_CYCLES_W
)
(
  // clock and resets
  input wire logic clk,
  input wire logic rstn,
  input wire logic por_n,
  // pins
  input wire logic ext_reset_n,
  input wire logic irq_test_high_voltage,
  input wire logic rst_test_high_voltage,
  input wire logic [15:0] cpu_vec_addr,
  // results
  input wire logic [15:0] vec_addr,
  input wire logic host_serial_pin_oe,
  input wire logic monitor_mode,
  input wire logic [1:0] clk_sel,
  input wire logic osc_bypass,
  input wire logic pll_enable,
  input wire logic watchdog_disable,
  input wire logic extra_reset_req
);
  // ----------------------------------------
  // break length counter
  // ----------------------------------------
  localparam logic [15:0] BRK_LEN = 16'(BREAK_BITS * BIT_LEN);
  logic [15:0] brk_r;
  logic [15:0] brk_nxt;
  always_comb brk_nxt = host_serial_pin_oe ? brk_r + 16'h0001 : 16'h0000;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) brk_r <= 16'h0000;
    else brk_r <= brk_nxt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_reset_remap: assert property (monitor_mode && cpu_vec_addr == USER_RESET_VEC
    |-> vec_addr == MON_RESET_VEC) else $error("reset vector remap");
  chk_swi_remap: assert property (monitor_mode && cpu_vec_addr == USER_SWI_VEC
    |-> vec_addr == MON_SWI_VEC) else $error("swi vector remap");
  chk_mode_latch: assert property (por_n && $changed(monitor_mode)
    |-> $past(ext_reset_n) && !$past(ext_reset_n, 2)) else $error("mode moved");
  chk_hv_watchdog: assert property (monitor_mode && osc_bypass
    && (irq_test_high_voltage || rst_test_high_voltage) |-> watchdog_disable)
    else $error("watchdog on");
  chk_user_mode: assert property (!monitor_mode
    |-> !watchdog_disable && !osc_bypass && clk_sel == CLK_XTAL) else $error("user");
  chk_pll_sel: assert property (pll_enable |-> clk_sel == CLK_PLL && monitor_mode)
    else $error("pll select");
  chk_extra_reset: assert property (extra_reset_req
    |-> monitor_mode && !osc_bypass && watchdog_disable) else $error("extra reset");
  chk_break_len: assert property ($fell(host_serial_pin_oe) |-> brk_r == BRK_LEN)
    else $error("break length");
endmodule

// >>> mon_host_model.sv
// model: host end of the monitor link
// assumes: pin pulled up; host only pulls it low
`timescale 1ns/1ps
module mon_host_model
  import mon_entry_pkg::*;
#(
  parameter logic [12:0] BIT_LEN = BIT_CYCLES_W
)
(
  // clock
  input wire logic clk,
  // pull-down request on the pin
  output logic tx_low
);
  initial tx_low = 1'b0;
  // idle gap in bits lets the host be prompt or slow
  task automatic send(input logic [7:0] b, input int gap);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    repeat (gap * BIT_LEN + 1) @(posedge clk);
    for (int i = 0; i < FRAME_BITS; i++) begin
      tx_low <= !f[i];
      repeat (BIT_LEN) @(posedge clk);
    end
    tx_low <= 1'b0;
  endtask
endmodule

// >>> test_monitor_mode_entry_control.sv
// bench: entry modes, watchdog, vectors, link opening
// assumes: host model on the wired pin, one 50 MHz clock
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
  $display("Error %0t %h %h", $time, a, b); end end
module test_monitor_mode_entry_control;
  import mon_entry_pkg::*;
  // short bit time keeps the run brief; the link logic is the same at full baud
  localparam logic [12:0] BL = 13'h0020;
  logic clk = 0, rstn = 0, por_n = 0, erst = 0, s1 = 0, s2 = 0, dv = 0, irq = 1;
  logic ihv = 0, rhv = 0, low = 0, pin, host_low, oe, po, mm, sc, ob, pe, wd, xrq, cr, cs;
  logic [7:0] ns = 8'h00;
  logic [15:0] vec = 16'hFFFF, cva = 16'hFFFE, va;
  logic [1:0] cks;
  int failures = 0, samples_checked = 0, xr;
  always #10 clk = ~clk;
  // start pulses counted off the edge, where they are settled
  always @(negedge clk) ns <= ns + {7'h00, cs};
  // pull-up: any driver pulls low
  assign pin = ~((oe & ~po) | host_low | low);
  mon_host_model #(.BIT_LEN(BL)) host (.clk(clk), .tx_low(host_low));
  monitor_mode_entry_control #(.BIT_LEN(BL)) dut (.clk(clk), .rstn(rstn), .por_n(por_n),
    .ext_reset_n(erst), .entry_strap_pin_one(s1), .entry_strap_pin_two(s2),
    .clock_divider_select_pin(dv), .entry_interrupt_pin(irq),
    .irq_test_high_voltage(ihv), .rst_test_high_voltage(rhv),
    .vec_byte_hi(vec[15:8]), .vec_byte_lo(vec[7:0]), .cpu_vec_addr(cva),
    .vec_addr(va), .host_serial_pin_in(pin), .host_serial_pin_out(po),
    .host_serial_pin_oe(oe), .monitor_mode(mm), .serial_comm(sc), .clk_sel(cks),
    .osc_bypass(ob), .pll_enable(pe), .watchdog_disable(wd),
    .extra_reset_req(xrq), .cmd_ready(cr), .cmd_start(cs));
  task w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wrap_up;
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task enter(input logic hv, input logic [15:0] v, input logic i, input logic d);
    @(posedge clk);
    ihv <= hv;
    vec <= v;
    irq <= i;
    dv <= d;
    erst <= 0;
    w(3);
    erst <= 1;
    xr = 0;
    repeat (4) begin
      @(negedge clk);
      xr += xrq;
    end
  endtask
  task s_hv;
    @(posedge clk);
    low <= 1;
    enter(1, 16'h1234, 1, 0);
    `CHK({mm, sc, cks, ob, wd, va}, {2'b10, CLK_DIV2, 2'b11, MON_RESET_VEC})
    @(posedge clk);
    low <= 0;
    s1 <= 1;
    s2 <= 1;
    dv <= 1;
    rhv <= 1;
    cva <= USER_SWI_VEC;
    w(2);
    ihv <= 0;
    @(negedge clk);
    `CHK({mm, cks, wd, va}, {1'b1, CLK_DIV2, 1'b1, MON_SWI_VEC})
    @(posedge clk);
    rhv <= 0;
    @(negedge clk);
    `CHK(wd, 1'b0)
    enter(1, 16'h1234, 1, 1);
    `CHK({mm, cks, va}, {1'b0, CLK_XTAL, USER_SWI_VEC})
    @(posedge clk);
    s2 <= 0;
    enter(1, 16'h1234, 1, 1);
    `CHK({mm, cks, ob}, {1'b1, CLK_DIV4, 1'b1})
  endtask
  task s_blank;
    enter(0, 16'hFFFE, 1, 0);
    `CHK({mm, wd}, 2'b00)
    enter(0, 16'hFFFF, 1, 0);
    `CHK({mm, sc, cks, pe, wd, xr[1:0]}, {2'b11, CLK_DIV4, 2'b01, 2'b01})
    enter(0, 16'h1234, 0, 0);
    `CHK({mm, cks, wd}, {1'b1, CLK_DIV4, 1'b1})
    @(posedge clk);
    por_n <= 0;
    w(2);
    por_n <= 1;
    @(negedge clk);
    `CHK(mm, 1'b0)
    enter(0, 16'hFFFF, 0, 0);
    `CHK({mm, cks, pe, ob, xr[1:0]}, {1'b1, CLK_PLL, 2'b10, 2'b01})
  endtask
  task s_link;
    int n;
    for (int i = 0; i < SECURITY_BYTES - 1; i++) host.send(8'hA5 ^ 8'(i), 1);
    w(2 * BL);
    @(negedge clk);
    `CHK(oe, 1'b0)
    host.send(8'h5A, 3);
    n = 0;
    while (oe !== 1'b1 && n < 4 * BL) begin
      @(negedge clk);
      n++;
    end
    `CHK(pin, 1'b0)
    n = 0;
    while (oe === 1'b1 && n < 20 * BL) begin
      @(negedge clk);
      n++;
    end
    if (n == 0 || n >= 20 * BL) begin
      failures++;
      return;
    end
    `CHK(n, BREAK_BITS * BL)
    w(BL);
    `CHK({cr, ns}, {1'b1, 8'h00})
    host.send(8'h4A, 1);
    `CHK({cr, ns}, {1'b0, 8'h01})
  endtask
  initial begin
    w(16);
    rstn <= 1;
    por_n <= 1;
    @(negedge clk);
    `CHK({mm, cks, oe, wd, va}, {1'b0, CLK_XTAL, 2'b00, 16'hFFFE})
    s_hv;
    s_blank;
    s_link;
    wrap_up;
  end
endmodule
bind monitor_mode_entry_control mon_entry_properties #(.BIT_LEN(BIT_LEN)) chk (
  .clk(clk),
  .rstn(rstn),
  .por_n(por_n),
  .ext_reset_n(ext_reset_n),
  .irq_test_high_voltage(irq_test_high_voltage),
  .rst_test_high_voltage(rst_test_high_voltage),
  .cpu_vec_addr(cpu_vec_addr),
  .vec_addr(vec_addr),
  .host_serial_pin_oe(host_serial_pin_oe),
  .monitor_mode(monitor_mode),
  .clk_sel(clk_sel),
  .osc_bypass(osc_bypass),
  .pll_enable(pll_enable),
  .watchdog_disable(watchdog_disable),
  .extra_reset_req(extra_reset_req));
